// File: pkg/dcrb_map.svh
/*
 * offsets, field positions, reset values and timing figures of the driver control registers.
 * assumes a 50 MHz system clock and a same-clock register access port from the serial front end.
 */
`ifndef DCRB_MAP_SVH
`define DCRB_MAP_SVH

// ************************************************************
// register indices and write masks
// ************************************************************
`define DCRB_IDX_MONREC      4'h3
`define DCRB_IDX_BRIDGE      4'h4
`define DCRB_IDX_PWMDUTY     4'h5
`define DCRB_MASK_MONREC     16'hf7bf
`define DCRB_MASK_BRIDGE     16'hffff
`define DCRB_MASK_PWMDUTY    16'h7fff
`define DCRB_RST_MONREC      16'h0000
`define DCRB_RST_BRIDGE      16'h003c
`define DCRB_RST_PWMDUTY     16'h0000

// ************************************************************
// field positions
// ************************************************************
`define DCRB_POS_OCR_EN      15
`define DCRB_POS_PWM_EN      10
`define DCRB_POS_REC_RATE    5
`define DCRB_POS_FAULT_LATCH 4
`define DCRB_POS_PWM_RATE    7
`define DCRB_MON_FIRST       4'h5
`define DCRB_MON_LAST        4'ha

// ************************************************************
// timing
// ************************************************************
`define DCRB_CLK_HZ          50000000
`define DCRB_REC_SLOW_HZ     1700
`define DCRB_REC_FAST_HZ     3000
`define DCRB_PWM_SLOW_HZ     122
`define DCRB_PWM_FAST_HZ     244
`define DCRB_PWM_STEPS       128
`define DCRB_PWM_SLOW_CYC    (`DCRB_CLK_HZ / (`DCRB_PWM_SLOW_HZ * `DCRB_PWM_STEPS))
`define DCRB_PWM_FAST_CYC    (`DCRB_CLK_HZ / (`DCRB_PWM_FAST_HZ * `DCRB_PWM_STEPS))

`endif

// File: pkg/dcrb_pkg.sv
/*
 * types of the driver control register bank.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package dcrb_pkg;

   // ************************************************************
   // bridge gate control register contents, msb first
   // ************************************************************
   typedef struct packed {
      logic [4:0] slew_current;                         // gate slew current code
      logic       bridge_openload_high_threshold;       // 5/6 supply threshold
      logic       openload_test_first_high_second_low;  // test path high one to low two
      logic       openload_test_second_high_first_low;  // test path high two to low one
      logic       slow_decay;                           // slow decay mode
      logic       slow_decay_single;                    // single side slow decay
      logic [3:0] cross_conduction_guard_time;          // dead time code
      logic [1:0] drain_source_threshold;               // ds monitor threshold
   } dcrb_bridge_s;

   // supply fault lockout states
   typedef enum logic [0:0] {
      DCRB_SF_RUN  = 1'b0,
      DCRB_SF_LOCK = 1'b1
   } dcrb_fault_e;

endpackage

// File: logic/dcrb_top.sv
/*
 * driver control register bank: monitor/recovery, bridge gate and pwm duty registers,
 * with the pwm timers, overcurrent retry, supply fault lockout and monitor select they steer.
 * assumes the serial front end presents decoded register writes and reads on the same clock;
 * fault and overcurrent flags arrive from analog comparators, outside the clock domain.
 */
`timescale 1ns/1ps
`include "dcrb_map.svh"

// Operation
// - recovery rate bit picks 1.7kHz or 3kHz
// - latched supply fault holds drivers off until cleared
// - monitor codes 5..10 route outputs five..ten
// - other monitor codes deactivate monitor, high impedance
// - bridge slew current field bits 15..11
// - threshold bit selects high open-load threshold
// - bit 9 tests high one to low two
// - bit 8 tests high two to low one
// - guard time field resets to all ones
// - drain-source threshold field bits 1..0
// - pwm rate bit picks 122Hz or 244Hz
// - duty channel two in bits 14..8
// - duty channel one in bits 6..0
// - timer enable makes output follow pwm timer
// - recovery enable retries output after overcurrent
module dcrb_top #(
   parameter int N_OUT    = 2,                                       // outputs seven and eight
   parameter int REC_SLOW = `DCRB_CLK_HZ / `DCRB_REC_SLOW_HZ,        // recovery period, slow
   parameter int REC_FAST = `DCRB_CLK_HZ / `DCRB_REC_FAST_HZ         // recovery period, fast
) (
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 reset_n,
   // register access port
   input  wire logic [3:0]           reg_index,
   input  wire logic [15:0]          reg_wdata,
   input  wire logic                 reg_write,
   output logic      [15:0]          reg_rdata,
   // output requests and faults
   input  wire logic [N_OUT-1:0]     output_on_request,
   input  wire logic [N_OUT-1:0]     overcurrent_pin,
   input  wire logic                 supply_fault_pin,
   input  wire logic                 supply_fault_clear,
   // driver and monitor controls
   output logic      [N_OUT-1:0]     output_drive,
   output logic      [1:0]           pwm_level,
   output dcrb_pkg::dcrb_bridge_s    bridge_cfg,
   output logic      [5:0]           current_monitor_route,
   output logic                      current_monitor_pin_oe_n
);

   // ************************************************************
   // registers and state
   // ************************************************************
   logic [15:0]               monrec_reg;          // monitor and recovery control
   logic [15:0]               bridge_reg;          // bridge gate control
   logic [15:0]               pwmduty_reg;         // pwm rate and duty
   logic [15:0]               rdata_reg;           // read answer
   logic [N_OUT-1:0]          oc_meta_reg;         // overcurrent sync stage one
   logic [N_OUT-1:0]          oc_sync_reg;         // overcurrent sync stage two
   logic                      sf_meta_reg;         // supply fault sync stage one
   logic                      sf_sync_reg;         // supply fault sync stage two
   dcrb_pkg::dcrb_fault_e     sf_state_reg;        // supply fault lockout
   logic [15:0]               rec_cnt_reg;         // recovery divider
   logic                      rec_tick;            // one-cycle recovery enable
   logic [11:0]               step_cnt_reg;        // pwm step divider
   logic                      step_tick;           // one-cycle pwm step enable
   logic [6:0]                pwm_cnt_reg;         // pwm phase within period
   logic [1:0]                pwm_reg;             // pwm timer levels
   logic [N_OUT-1:0]          oc_off_reg;          // output tripped by overcurrent
   logic [N_OUT-1:0]          drive_reg;           // output drive
   logic [5:0]                mon_route_reg;       // monitor one-hot route
   logic                      mon_oe_n_reg;        // monitor pin enable, low drives
   logic                      drv_block;           // supply fault blocks drivers
   logic [15:0]               rec_limit;           // selected recovery period
   logic [11:0]               step_limit;          // selected pwm step period

   // monitor code names an existing output
   function automatic logic mon_valid(input logic [3:0] code);
      mon_valid = (code >= `DCRB_MON_FIRST) && (code <= `DCRB_MON_LAST);
   endfunction

   // ************************************************************
   // register writes and reads
   // ************************************************************
   // reserved bits are masked so they always read zero even if the host slips
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         monrec_reg  <= `DCRB_RST_MONREC;
         bridge_reg  <= `DCRB_RST_BRIDGE;
         pwmduty_reg <= `DCRB_RST_PWMDUTY;
      end else if (reg_write) begin
         case (reg_index)
            `DCRB_IDX_MONREC:  monrec_reg  <= reg_wdata & `DCRB_MASK_MONREC;
            `DCRB_IDX_BRIDGE:  bridge_reg  <= reg_wdata & `DCRB_MASK_BRIDGE;
            `DCRB_IDX_PWMDUTY: pwmduty_reg <= reg_wdata & `DCRB_MASK_PWMDUTY;
            default: begin
               // other indices belong elsewhere
            end
         endcase
      end
   end

   // read answer one cycle after the index; unmapped indices read zero
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_reg <= 16'h0000;
      end else begin
         case (reg_index)
            `DCRB_IDX_MONREC:  rdata_reg <= monrec_reg;
            `DCRB_IDX_BRIDGE:  rdata_reg <= bridge_reg;
            `DCRB_IDX_PWMDUTY: rdata_reg <= pwmduty_reg;
            default:           rdata_reg <= 16'h0000;
         endcase
      end
   end

   // ************************************************************
   // input synchronisers
   // ************************************************************
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         oc_meta_reg <= '0;
         oc_sync_reg <= '0;
         sf_meta_reg <= 1'b0;
         sf_sync_reg <= 1'b0;
      end else begin
         oc_meta_reg <= overcurrent_pin;
         oc_sync_reg <= oc_meta_reg;
         sf_meta_reg <= supply_fault_pin;
         sf_sync_reg <= sf_meta_reg;
      end
   end

   // ************************************************************
   // dividers: recovery rate and pwm step rate
   // ************************************************************
   assign rec_limit  = monrec_reg[`DCRB_POS_REC_RATE] ? 16'(REC_FAST - 1) : 16'(REC_SLOW - 1);
   assign step_limit = pwmduty_reg[`DCRB_POS_PWM_RATE] ? 12'(`DCRB_PWM_FAST_CYC - 1)
                                                       : 12'(`DCRB_PWM_SLOW_CYC - 1);
   assign rec_tick   = (rec_cnt_reg >= rec_limit);
   assign step_tick  = (step_cnt_reg >= step_limit);

   // >= rather than == so a rate change to a shorter period never overruns
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rec_cnt_reg  <= 16'h0000;
         step_cnt_reg <= 12'h000;
      end else begin
         rec_cnt_reg  <= rec_tick ? 16'h0000 : rec_cnt_reg + 16'h0001;
         step_cnt_reg <= step_tick ? 12'h000 : step_cnt_reg + 12'h001;
      end
   end

   // ************************************************************
   // pwm timers
   // ************************************************************
   // 128 steps per period; duty zero never turns on
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pwm_cnt_reg <= 7'h00;
         pwm_reg     <= 2'h0;
      end else begin
         if (step_tick) begin
            pwm_cnt_reg <= pwm_cnt_reg + 7'h01;
         end
         pwm_reg[0] <= (pwm_cnt_reg < pwmduty_reg[6:0]);
         pwm_reg[1] <= (pwm_cnt_reg < pwmduty_reg[14:8]);
      end
   end

   // ************************************************************
   // supply fault lockout
   // ************************************************************
   // a fault present during the clear keeps the lock: the event wins
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sf_state_reg <= dcrb_pkg::DCRB_SF_RUN;
      end else begin
         case (sf_state_reg)
            dcrb_pkg::DCRB_SF_RUN: begin
               if (sf_sync_reg && monrec_reg[`DCRB_POS_FAULT_LATCH]) begin
                  sf_state_reg <= dcrb_pkg::DCRB_SF_LOCK;
               end
            end
            dcrb_pkg::DCRB_SF_LOCK: begin
               if (supply_fault_clear && !sf_sync_reg) begin
                  sf_state_reg <= dcrb_pkg::DCRB_SF_RUN;
               end
            end
            default: sf_state_reg <= dcrb_pkg::DCRB_SF_RUN;
         endcase
      end
   end

   assign drv_block = sf_sync_reg || (sf_state_reg == dcrb_pkg::DCRB_SF_LOCK);

   // ************************************************************
   // per-output trip, retry and drive
   // ************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < N_OUT; gi++) begin : g_out
         // tripped output retries on a recovery tick if enabled, else waits for request drop
         always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               oc_off_reg[gi] <= 1'b0;
            end else if (!output_on_request[gi]) begin
               oc_off_reg[gi] <= 1'b0;
            end else if (oc_off_reg[gi] && rec_tick && monrec_reg[`DCRB_POS_OCR_EN - gi]) begin
               oc_off_reg[gi] <= 1'b0;
            end else if (oc_sync_reg[gi] && drive_reg[gi]) begin
               oc_off_reg[gi] <= 1'b1;
            end
         end

         // static on, or gated by its timer when the timer enable is set
         always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               drive_reg[gi] <= 1'b0;
            end else begin
               drive_reg[gi] <= output_on_request[gi] && !oc_off_reg[gi] && !drv_block &&
                                (!monrec_reg[`DCRB_POS_PWM_EN - gi] || pwm_reg[gi]);
            end
         end
      end
   endgenerate

   // ************************************************************
   // current monitor route
   // ************************************************************
   // unused codes release the pin rather than pick a default output
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mon_route_reg <= 6'h00;
         mon_oe_n_reg  <= 1'b1;
      end else if (mon_valid(monrec_reg[3:0])) begin
         mon_route_reg <= 6'h01 << (monrec_reg[3:0] - `DCRB_MON_FIRST);
         mon_oe_n_reg  <= 1'b0;
      end else begin
         mon_route_reg <= 6'h00;
         mon_oe_n_reg  <= 1'b1;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   // bridge fields go straight out of the register flops
   assign bridge_cfg               = bridge_reg;
   assign reg_rdata                = rdata_reg;
   assign output_drive             = drive_reg;
   assign pwm_level                = pwm_reg;
   assign current_monitor_route    = mon_route_reg;
   assign current_monitor_pin_oe_n = mon_oe_n_reg;

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   rec_period_a: assert property (rec_cnt_reg <= 16'(REC_SLOW - 1))
      else $error("recovery divider overran");
   fault_lock_a: assert property (sf_state_reg == dcrb_pkg::DCRB_SF_LOCK |=> drive_reg == '0)
      else $error("driver on while supply fault locked");
   monitor_route_a: assert property (mon_valid(monrec_reg[3:0]) |=>
         !mon_oe_n_reg && mon_route_reg == 6'h01 << ($past(monrec_reg[3:0]) - `DCRB_MON_FIRST))
      else $error("monitor routed to wrong output");
   monitor_off_a: assert property (!mon_valid(monrec_reg[3:0]) |=> mon_oe_n_reg && mon_route_reg == 6'h00)
      else $error("monitor active on invalid code");
   reserved_zero_a: assert property (!pwmduty_reg[15] && !monrec_reg[11] && !monrec_reg[6])
      else $error("reserved bit stored");
   step_rate_a: assert property (step_cnt_reg <= 12'(`DCRB_PWM_SLOW_CYC - 1))
      else $error("pwm step divider overran");
   duty_zero_a: assert property (pwmduty_reg[6:0] == 7'h00 |=> !pwm_reg[0])
      else $error("zero duty turned timer on");
   duty_on_a: assert property (pwm_cnt_reg < pwmduty_reg[14:8] |=> pwm_reg[1])
      else $error("timer two off inside on time");
   static_on_a: assert property (output_on_request[0] && !oc_off_reg[0] && !drv_block &&
         !monrec_reg[`DCRB_POS_PWM_EN] |=> drive_reg[0])
      else $error("static output not driven");
   retry_clear_a: assert property (oc_off_reg[0] && rec_tick && output_on_request[0] &&
         monrec_reg[`DCRB_POS_OCR_EN] |=> !oc_off_reg[0])
      else $error("enabled recovery did not retry");

endmodule

// File: sim/dcrb_host_model.sv
/*
 * host side of the register access port: issues whole 16-bit register writes and reads.
 * assumes the bank samples requests on the rising clock edge and answers reads one edge later.
 */
`timescale 1ns/1ps
module dcrb_host_model (
   // clock
   input  wire logic        clk,
   // register access port
   output logic      [3:0]  reg_index,
   output logic      [15:0] reg_wdata,
   output logic             reg_write,
   input  wire logic [15:0] reg_rdata
);
   // ************************************************************
   // access tasks
   // ************************************************************
   // idle port at time zero
   initial begin
      reg_index = 4'h0;
      reg_wdata = 16'h0000;
      reg_write = 1'b0;
   end

   // one write strobe; reserved bits are always sent as zero
   task automatic write_reg(input logic [3:0] idx, input logic [15:0] data);
      logic [15:0] keep;
      keep = (idx == 4'h3) ? 16'hf7bf : ((idx == 4'h5) ? 16'h7fff : 16'hffff);
      @(posedge clk);
      #1;
      reg_index = idx;
      reg_wdata = data & keep;
      reg_write = 1'b1;
      @(posedge clk);
      #1;
      reg_write = 1'b0;
      reg_wdata = ~reg_wdata; // released data shows no stale copy
   endtask

   // index held for two edges so the registered answer has settled
   task automatic read_reg(input logic [3:0] idx, output logic [15:0] data);
      @(posedge clk);
      #1;
      reg_index = idx;
      repeat (2) @(posedge clk);
      #1;
      data = reg_rdata;
   endtask
endmodule

// File: sim/tb_top.sv
/*
 * self-checking bench of the driver control register bank.
 * assumes the host model above and short recovery periods of 40 and 20 cycles.
 */
`timescale 1ns/1ps
module tb_top;
   // ************************************************************
   // signals
   // ************************************************************
   logic                   clk, reset_n;                   // clock and reset
   logic [3:0]             reg_index;                      // register port
   logic [15:0]            reg_wdata, reg_rdata, rv;       // data and read value
   logic                   reg_write;                      // write strobe
   logic [1:0]             output_on_request, overcurrent_pin, output_drive, pwm_level;
   logic                   supply_fault_pin, supply_fault_clear;
   dcrb_pkg::dcrb_bridge_s bridge_cfg;                     // bridge controls
   logic [5:0]             current_monitor_route;          // one-hot monitor route
   logic                   current_monitor_pin_oe_n;       // monitor pin enable
   logic [15:0]            pat [5];                        // bridge patterns
   logic [3:0]             watch;                          // pwm levels over drives
   int                     err_total, cmp_count, n;        // counters

   dcrb_top #(.REC_SLOW(40), .REC_FAST(20)) dut (
      .clk(clk), .reset_n(reset_n), .reg_index(reg_index), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_rdata(reg_rdata), .output_on_request(output_on_request),
      .overcurrent_pin(overcurrent_pin), .supply_fault_pin(supply_fault_pin),
      .supply_fault_clear(supply_fault_clear), .output_drive(output_drive), .pwm_level(pwm_level),
      .bridge_cfg(bridge_cfg), .current_monitor_route(current_monitor_route),
      .current_monitor_pin_oe_n(current_monitor_pin_oe_n));

   dcrb_host_model host (.clk(clk), .reg_index(reg_index), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_rdata(reg_rdata));

   assign watch = {pwm_level, output_drive};

   // 50 MHz clock
   initial clk = 1'b0;
   always #10 clk = ~clk;

   // ************************************************************
   // helpers
   // ************************************************************
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // compare of design values
   task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   // compare of measured cycle counts
   task automatic check_count(input string what, input int exp, input int got);
      cmp_count++;
      if (got != exp) begin
         err_total++;
         $display("ERROR %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   task automatic cycles(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   task automatic read_chk(input logic [3:0] idx, input logic [15:0] exp);
      host.read_reg(idx, rv);
      check_word("reg_rdata", exp, rv);
   endtask

   // bounded wait on one bit of {pwm_level, output_drive}; a timeout ends the run
   task automatic wait_bit(input int sel, input logic v, input int lim);
      int i;
      for (i = 0; i < lim && watch[sel] !== v; i++) cycles(1);
      check_word("watched bit", {15'h0000, v}, {15'h0000, watch[sel]});
      if (i >= lim) complete_run();
   endtask

   // ************************************************************
   // tests
   // ************************************************************
   initial begin
      reset_n = 1'b0;
      output_on_request = 2'b11;
      overcurrent_pin = 2'b00;
      supply_fault_pin = 1'b0;
      supply_fault_clear = 1'b0;
      err_total = 0;
      cmp_count = 0;
      pat = '{16'hf800, 16'h0400, 16'h0200, 16'h0100, 16'h00c3};
      repeat (4) @(posedge clk);
      #1;
      reset_n = 1'b1;
      // reset values, unmapped index reads zero
      check_word("bridge_cfg", 16'h003c, bridge_cfg);
      check_word("monitor oe_n", 16'h0001, {15'h0000, current_monitor_pin_oe_n});
      read_chk(4'h3, 16'h0000);
      read_chk(4'h4, 16'h003c);
      read_chk(4'h5, 16'h0000);
      read_chk(4'h7, 16'h0000);
      $display("test reset values done");
      // slew, threshold and both test bits alone, then decay and ds threshold bits together, each with readback
      foreach (pat[i]) begin
         host.write_reg(4'h4, pat[i]);
         cycles(2);
         check_word("bridge_cfg", pat[i], bridge_cfg);
         read_chk(4'h4, pat[i]);
      end
      $display("test bridge fields done");
      // every monitor select code
      for (int c = 0; c < 16; c++) begin
         host.write_reg(4'h3, 16'(c));
         cycles(3);
         check_word("route", (c >= 5 && c <= 10) ? 16'(1 << (c - 5)) : 16'h0000,
                    {10'h000, current_monitor_route});
         check_word("oe_n", (c >= 5 && c <= 10) ? 16'h0000 : 16'h0001,
                    {15'h0000, current_monitor_pin_oe_n});
      end
      $display("test monitor select done");
      // duty fields and rate bit
      host.write_reg(4'h5, 16'h7f7f);
      read_chk(4'h5, 16'h7f7f);
      host.write_reg(4'h5, 16'h0080);
      read_chk(4'h5, 16'h0080);
      // output 7 follows timer 1, output 8 stays statically on
      host.write_reg(4'h5, 16'h0000);
      host.write_reg(4'h3, 16'h0400);
      cycles(3300);
      check_word("drive", 16'h0002, {14'h0000, output_drive});
      host.write_reg(4'h5, 16'h007f);
      wait_bit(0, 1'b1, 3300);
      check_word("pwm_level", 16'h0001, {14'h0000, pwm_level});
      host.write_reg(4'h5, 16'h7f00);
      wait_bit(3, 1'b1, 3300);
      wait_bit(0, 1'b0, 6);
      host.write_reg(4'h3, 16'h0000);
      $display("test pwm done");
      // supply fault, without then with the latch
      for (int lat = 0; lat < 2; lat++) begin
         host.write_reg(4'h3, 16'(lat << 4));
         wait_bit(0, 1'b1, 6);
         supply_fault_pin = 1'b1;
         cycles(4);
         supply_fault_pin = 1'b0;
         cycles(10);
         check_word("drive after fault", 16'(1 - lat), {15'h0000, output_drive[0]});
         supply_fault_clear = 1'b1;
         cycles(1);
         supply_fault_clear = 1'b0;
         wait_bit(0, 1'b1, 5);
      end
      $display("test supply fault done");
      // overcurrent retry period at both recovery rates
      for (int r = 0; r < 2; r++) begin
         host.write_reg(4'h3, 16'h8000 | 16'(r << 5));
         overcurrent_pin = 2'b01;
         wait_bit(0, 1'b0, 8);
         wait_bit(0, 1'b1, 60);
         n = 0;
         do begin
            rv[0] = output_drive[0];
            cycles(1);
            n++;
         end while (!(rv[0] === 1'b0 && output_drive[0] === 1'b1) && n < 200);
         check_count("retry period", r ? 20 : 40, n);
         overcurrent_pin = 2'b00;
         cycles(50);
      end
      // without recovery the output stays off until the request drops
      host.write_reg(4'h3, 16'h0000);
      overcurrent_pin = 2'b01;
      cycles(5);
      overcurrent_pin = 2'b00;
      cycles(60);
      check_word("drive held off", 16'h0000, {15'h0000, output_drive[0]});
      output_on_request = 2'b10;
      cycles(3);
      output_on_request = 2'b11;
      wait_bit(0, 1'b1, 5);
      $display("test overcurrent done");
      // pwm step length at both rates, timed from a reset in mid-run
      for (int f = 0; f < 2; f++) begin
         reset_n = 1'b0;
         cycles(2);
         reset_n = 1'b1;
         read_chk(4'h5, 16'h0000);
         host.write_reg(4'h5, 16'h0201 | 16'(f << 7));
         wait_bit(2, 1'b1, 4);
         wait_bit(2, 1'b0, 3300);
         n = 0;
         while (pwm_level[1] === 1'b1 && n < 4000) begin
            cycles(1);
            n++;
         end
         check_count("pwm step", f ? 1600 : 3201, n);
      end
      $display("test pwm rate done");
      complete_run();
   end
endmodule
